// ==== dv/program_flow_stack_and_alu_ops_tb.sv ====
`include "flow_cfg.svh"
module program_flow_stack_and_alu_ops_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import flow_pkg::*;
	logic clk_sys = 1'b0, rst = 1'b1, instr_valid = 1'b0, page_sel_we = 1'b0, counter_low_byte_we = 1'b0;
	logic [11:0] instr = 12'h000;
	logic [1:0] page_select_bits = 2'h0, page_sel_wdata = 2'h0, page_sel;
	logic [7:0] counter_low_byte_wdata = 8'h00, reg_rdata, reg_wdata, accum, w, f, r;
	logic [10:0] pc, exp_pc, s1, s2, e;
	logic [4:0] reg_addr;
	logic reg_we, flag_c, flag_dc, flag_z, discard, d;
	exec_state_t exec_state;
	int error_cnt = 0, checks_done = 0, i;
	////////////////////////////////////////////////////////////////
	// The core clock runs at 40 MHz.
	always #12.5 clk_sys = ~clk_sys;
	program_flow #(.AW(11)) program_flow_inst (.clk_sys, .rst, .instr, .instr_valid, .reg_rdata,
		.page_select_bits, .page_sel_we, .page_sel_wdata, .counter_low_byte_we, .counter_low_byte_wdata,
		.pc, .page_sel, .reg_addr, .reg_we, .reg_wdata, .accum, .flag_c, .flag_dc, .flag_z, .discard, .exec_state);
	reg_file_model reg_file_model_inst (.clk_sys, .reg_addr, .reg_we, .reg_wdata, .reg_rdata);
	////////////////////////////////////////////////////////////////
	// Subtraction reference: carry, digit carry, zero, then the difference.
	function automatic logic [10:0] sub_exp(input logic [7:0] a, input logic [7:0] b);
		logic [7:0] res;
		res = a - b;
		return {a >= b, a[3:0] >= b[3:0], res == 8'h00, res};
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Presents one word for one edge, then returns once the results have settled.
	task automatic step(input logic [11:0] word, input logic vld);
		instr = word;
		instr_valid = vld;
		@(posedge clk_sys);
		#2;
	endtask
	task automatic print_verdict();
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// A hung run is cut short and counted as a mismatch.
	initial begin
		repeat (5000) @(posedge clk_sys);
		error_cnt++;
		print_verdict();
	end
	////////////////////////////////////////////////////////////////
	// Main sequence: paging, stack, then the register instructions.
	initial begin
		i = $urandom(32'ha3d9e886);
		repeat (3) @(posedge clk_sys);
		#2;
		chk(pc, 11'h7ff);
		chk(page_sel, 2'h0);
		rst = 1'b0;
		step({`OPC_GOTO_HI, 9'h1ff}, 1'b1);
		chk(pc, 11'h1ff);
		step(12'h000, 1'b1);
		chk({page_sel, pc}, 13'h0200);
		step({`OPC_GOTO_HI, 9'h005}, 1'b1);
		chk(pc, 11'h005);
		page_sel_wdata = 2'h2;
		page_sel_we = 1'b1;
		step(12'h000, 1'b0);
		page_sel_we = 1'b0;
		step({`OPC_GOTO_HI, 9'h1ff}, 1'b1);
		chk(pc, 11'h5ff);
		step(12'h000, 1'b1);
		chk({page_sel, pc}, 13'h1600);
		counter_low_byte_wdata = 8'h3c;
		counter_low_byte_we = 1'b1;
		step(12'h000, 1'b0);
		counter_low_byte_we = 1'b0;
		chk(pc, 11'h43c);
		exp_pc = 11'h43c;
		s1 = 11'h000;
		for (i = 1; i <= 3; i++) begin
			s2 = s1;
			s1 = exp_pc + 11'h001;
			exp_pc = {2'h2, 1'b0, 8'(i * 16)};
			step({`OPC_CALL_HI, 8'(i * 16)}, 1'b1);
			chk(pc, exp_pc);
		end
		for (i = 0; i < 3; i++) begin
			r = 8'($urandom);
			step({`OPC_RETURN_WITH_LITERAL_HI, r}, 1'b1);
			chk({accum, 5'h00, pc}, {r, 5'h00, s1});
			s1 = s2;
		end
		exp_pc = 11'h411;
		for (i = 0; i < 30; i++) begin
			w = (i < 3) ? 8'h02 : 8'($urandom);
			f = (i < 3) ? 8'(i + 1) : 8'($urandom);
			d = 1'($urandom);
			reg_file_model_inst.mem[5] = ~w;
			reg_file_model_inst.mem[6] = f;
			step({`OPC_COMPLEMENT, 1'b0, 5'h05}, 1'b1);
			chk({accum, flag_z}, {w, w == 8'h00});
			if (i > 0) chk({flag_c, flag_dc}, e[10:9]);
			step({`OPC_SUBTRACT, d, 5'h06}, 1'b1);
			e = sub_exp(f, w);
			chk({flag_c, flag_dc, flag_z}, e[10:8]);
			chk({reg_we, d ? reg_wdata : accum}, {d, e[7:0]});
			w = d ? w : e[7:0];
			step(12'h000, 1'b0);
			exp_pc = exp_pc + 11'h002;
		end
		for (i = 0; i < 4; i++) begin
			f = (i < 2) ? 8'(i + 1) : 8'($urandom);
			reg_file_model_inst.mem[7] = f;
			reg_file_model_inst.mem[5] = 8'h5a;
			step({`OPC_DEC_SKIP, 1'b1, 5'h07}, 1'b1);
			chk({reg_we, reg_wdata, discard, flag_c, flag_dc}, {1'b1, f - 8'h01, f == 8'h01, e[10:9]});
			chk(exec_state, (f == 8'h01) ? ST_FLUSH : ST_RUN);
			chk(reg_addr, 5'h07);
			step({`OPC_COMPLEMENT, 1'b0, 5'h05}, 1'b1);
			w = (f == 8'h01) ? w : 8'ha5;
			chk({accum, discard}, {w, 1'b0});
			chk(reg_file_model_inst.mem[7], 8'(f - 8'h01));
			exp_pc = exp_pc + 11'h002;
		end
		chk(pc, exp_pc);
		print_verdict();
	end
endmodule // program_flow_stack_and_alu_ops_tb

// ==== dv/reg_file_model.sv ====
module reg_file_model (
	input wire logic clk_sys,
	input wire logic [4:0] reg_addr,
	input wire logic reg_we,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] mem [32];
	logic [4:0] addr_q;
	////////////////////////////////////////////////////////////////
	// The read port follows the selected operand in the same cycle.
	assign reg_rdata = mem[reg_addr];
	// A write-back lands one cycle after execute, so the operand address is captured at execute.
	always @(posedge clk_sys) begin
		addr_q <= reg_addr;
		if (reg_we) begin
			mem[addr_q] <= reg_wdata;
		end
	end
endmodule // reg_file_model

// ==== rtl/flow_cfg.svh ====
`ifndef FLOW_CFG_SVH
`define FLOW_CFG_SVH
// Opcode fields of the 12-bit instruction word.
`define OPC_COMPLEMENT 6'h09
`define OPC_DEC_SKIP 6'h0b
`define OPC_SUBTRACT 6'h02
`define OPC_GOTO_HI 3'h5
`define OPC_CALL_HI 4'h9
`define OPC_RETURN_WITH_LITERAL_HI 4'h8
// Address of the counter low byte in the register file.
`define ADDR_COUNTER_LOW 5'h02
// Reset value of the page preselect bits.
`define PAGE_SEL_RESET 2'h0
`endif

// ==== rtl/flow_pkg.sv ====
package flow_pkg;
	// Decoded operation classes.
	typedef enum logic [2:0] {
		OP_NONE,
		OP_GOTO,
		OP_CALL,
		OP_RETURN_WITH_LITERAL,
		OP_COMPLEMENT_REGISTER,
		OP_DECREMENT_SKIP_ZERO,
		OP_SUBTRACT_ACCUM_FROM_REG
	} op_t;
	// Execution state: normal or flushing a discarded prefetch.
	typedef enum logic {
		ST_RUN,
		ST_FLUSH
	} exec_state_t;
endpackage

// ==== rtl/program_flow.sv ====
// Behaviour
// - Sequential increment crosses pages, page bits kept.
// - Jumps and counter writes use page bits.
// - Reset loads counter with last address.
// - Reset clears the page preselect bits.
// - Two-level stack, counter-wide levels.
// - Call shifts level one down, pushes counter+1.
// - Return loads counter, pops, loads literal.
// - Level two persists after being popped.
// - Destination bit picks accumulator or register.
// - Complement writes inverse, updates zero only.
// - Decrement-skip writes f-1, skips on zero.
// - Subtract writes f-W, updates C, DC, Z.
`include "flow_cfg.svh"
module program_flow #(
	parameter int AW = 11
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [11:0] instr,
	input wire logic instr_valid,
	input wire logic [7:0] reg_rdata,
	input wire logic [1:0] page_select_bits,
	input wire logic page_sel_we,
	input wire logic [1:0] page_sel_wdata,
	input wire logic counter_low_byte_we,
	input wire logic [7:0] counter_low_byte_wdata,
	output logic [AW-1:0] pc,
	output logic [1:0] page_sel,
	output logic [4:0] reg_addr,
	output logic reg_we,
	output logic [7:0] reg_wdata,
	output logic [7:0] accum,
	output logic flag_c,
	output logic flag_dc,
	output logic flag_z,
	output logic discard,
	output flow_pkg::exec_state_t exec_state
);
	import flow_pkg::*;

	localparam logic [AW-1:0] RESET_VEC = {AW{1'b1}};

	stack_if #(.AW(AW)) sif ();
	return_stack #(.AW(AW)) u_stack (.clk_sys(clk_sys), .rst(rst), .sif(sif));

	op_t op;
	logic [7:0] result;
	logic [8:0] diff;
	logic [4:0] ndiff;
	logic [1:0] page_sel_q;
	logic [AW-1:0] pc_q;
	exec_state_t state_q;
	logic go;

	// Places the page bits above an in-page address, so each page holds 2**(AW-2) words.
	function automatic logic [AW-1:0] paged(input logic [1:0] ps, input logic [AW-3:0] low);
		return {ps, low};
	endfunction

	// True for the register-oriented operations that write a destination.
	function automatic logic is_reg_op(input op_t code);
		return code == OP_COMPLEMENT_REGISTER || code == OP_DECREMENT_SKIP_ZERO || code == OP_SUBTRACT_ACCUM_FROM_REG;
	endfunction

	// Decode one instruction word.
	always_comb begin
		op = OP_NONE;
		if (instr[11:9] == `OPC_GOTO_HI) op = OP_GOTO;
		else if (instr[11:8] == `OPC_CALL_HI) op = OP_CALL;
		else if (instr[11:8] == `OPC_RETURN_WITH_LITERAL_HI) op = OP_RETURN_WITH_LITERAL;
		else if (instr[11:6] == `OPC_COMPLEMENT) op = OP_COMPLEMENT_REGISTER;
		else if (instr[11:6] == `OPC_DEC_SKIP) op = OP_DECREMENT_SKIP_ZERO;
		else if (instr[11:6] == `OPC_SUBTRACT) op = OP_SUBTRACT_ACCUM_FROM_REG;
	end

	assign go = instr_valid && state_q == ST_RUN;
	assign diff = {1'b0, reg_rdata} + {1'b0, ~accum} + 9'h001;
	assign ndiff = {1'b0, reg_rdata[3:0]} + {1'b0, ~accum[3:0]} + 5'h01;

	// Datapath result per operation.
	always_comb begin
		case (op)
			OP_COMPLEMENT_REGISTER: result = ~reg_rdata;
			OP_DECREMENT_SKIP_ZERO: result = reg_rdata - 8'h01;
			OP_SUBTRACT_ACCUM_FROM_REG: result = diff[7:0];
			default: result = 8'h00;
		endcase
	end

	assign reg_addr = instr[4:0];

	// Register write-back when the destination bit is set.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			reg_we <= 1'b0;
			reg_wdata <= 8'h00;
		end else begin
			reg_we <= go && instr[5] && is_reg_op(op);
			reg_wdata <= result;
		end
	end

	// Accumulator update.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			accum <= 8'h00;
		end else if (go) begin
			if (op == OP_RETURN_WITH_LITERAL) accum <= instr[7:0];
			else if (!instr[5] && is_reg_op(op)) accum <= result;
		end
	end

	// Status flags; decrement-skip leaves all of them alone.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			flag_c <= 1'b0;
			flag_dc <= 1'b0;
			flag_z <= 1'b0;
		end else if (go) begin
			if (op == OP_COMPLEMENT_REGISTER) flag_z <= (result == 8'h00);
			if (op == OP_SUBTRACT_ACCUM_FROM_REG) begin
				flag_c <= diff[8];
				flag_dc <= ndiff[4];
				flag_z <= (result == 8'h00);
			end
		end
	end

	// Page preselect bits.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) page_sel_q <= `PAGE_SEL_RESET;
		else if (page_sel_we) page_sel_q <= page_sel_wdata;
	end

	// Stack controls.
	assign sif.push = go && op == OP_CALL;
	assign sif.pop = go && op == OP_RETURN_WITH_LITERAL;
	assign sif.push_addr = pc_q + AW'(1);

	// Program counter.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			pc_q <= RESET_VEC;
		end else if (counter_low_byte_we) begin
			pc_q <= paged(page_sel_q, {1'b0, counter_low_byte_wdata});
		end else if (go) begin
			case (op)
				OP_GOTO: pc_q <= paged(page_sel_q, instr[8:0]);
				OP_CALL: pc_q <= paged(page_sel_q, {1'b0, instr[7:0]});
				OP_RETURN_WITH_LITERAL: pc_q <= sif.top_of_stack;
				default: pc_q <= pc_q + AW'(1);
			endcase
		end else if (instr_valid) begin
			pc_q <= pc_q + AW'(1);
		end
	end

	// Flush state for the skipped prefetch.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) state_q <= ST_RUN;
		else begin
			case (state_q)
				ST_RUN: if (go && op == OP_DECREMENT_SKIP_ZERO && result == 8'h00) state_q <= ST_FLUSH;
				ST_FLUSH: if (instr_valid) state_q <= ST_RUN;
				default: state_q <= ST_RUN;
			endcase
		end
	end

	assign pc = pc_q;
	assign page_sel = page_sel_q;
	assign discard = state_q == ST_FLUSH;
	assign exec_state = state_q;

	a_reset_vec: assert property (@(posedge clk_sys) $fell(rst) |-> pc_q == RESET_VEC)
		else $error("Counter not at reset vector.");
	a_page_clear: assert property (@(posedge clk_sys) $fell(rst) |-> page_sel_q == 2'h0)
		else $error("Page bits not cleared.");
	a_goto_page: assert property (@(posedge clk_sys) disable iff (rst)
		go && op == OP_GOTO && !counter_low_byte_we |=> pc_q[AW-1:AW-2] == $past(page_sel_q))
		else $error("Goto ignored page bits.");
	a_seq_incr: assert property (@(posedge clk_sys) disable iff (rst)
		go && op == OP_COMPLEMENT_REGISTER && !counter_low_byte_we |=> pc_q == $past(pc_q) + AW'(1))
		else $error("Counter did not increment.");
	a_return_with_literal_lit: assert property (@(posedge clk_sys) disable iff (rst)
		go && op == OP_RETURN_WITH_LITERAL |=> accum == $past(instr[7:0]))
		else $error("Literal not loaded.");
	a_complement_register_dest: assert property (@(posedge clk_sys) disable iff (rst)
		go && op == OP_COMPLEMENT_REGISTER && instr[5] |=> reg_we && reg_wdata == ~$past(reg_rdata))
		else $error("Complement not written back.");
	a_skip_two: assert property (@(posedge clk_sys) disable iff (rst)
		go && op == OP_DECREMENT_SKIP_ZERO && reg_rdata == 8'h01 |=> discard)
		else $error("Zero result did not skip.");
	a_skip_flags: assert property (@(posedge clk_sys) disable iff (rst)
		go && op == OP_DECREMENT_SKIP_ZERO |=> $stable(flag_z) && $stable(flag_c))
		else $error("Decrement-skip changed a flag.");
	a_sub_carry: assert property (@(posedge clk_sys) disable iff (rst)
		go && op == OP_SUBTRACT_ACCUM_FROM_REG |=> flag_c == ($past(reg_rdata) >= $past(accum)))
		else $error("Subtract carry wrong.");
	a_sub_dest: assert property (@(posedge clk_sys) disable iff (rst)
		go && op == OP_SUBTRACT_ACCUM_FROM_REG && !instr[5] |=> accum == $past(reg_rdata) - $past(accum))
		else $error("Subtract result wrong.");
	a_sub_zero: assert property (@(posedge clk_sys) disable iff (rst)
		go && op == OP_SUBTRACT_ACCUM_FROM_REG |=> flag_z == ($past(reg_rdata) == $past(accum)))
		else $error("Subtract zero flag wrong.");
	a_complement_register_flags: assert property (@(posedge clk_sys) disable iff (rst)
		go && op == OP_COMPLEMENT_REGISTER |=> $stable(flag_c) && $stable(flag_dc))
		else $error("Complement changed carry flags.");
	a_dec_write: assert property (@(posedge clk_sys) disable iff (rst)
		go && op == OP_DECREMENT_SKIP_ZERO && instr[5] |=> reg_we && reg_wdata == $past(reg_rdata) - 8'h01)
		else $error("Decrement not written back.");
	a_flush_ignore: assert property (@(posedge clk_sys) disable iff (rst)
		discard |=> $stable(accum) && !reg_we)
		else $error("Discarded word was executed.");
	a_call_page: assert property (@(posedge clk_sys) disable iff (rst)
		go && op == OP_CALL && !counter_low_byte_we |=> pc_q[7:0] == $past(instr[7:0]) && !pc_q[8]
			&& pc_q[AW-1:AW-2] == $past(page_sel_q))
		else $error("Call ignored page bits.");
	a_low_write: assert property (@(posedge clk_sys) disable iff (rst)
		counter_low_byte_we |=> pc_q[7:0] == $past(counter_low_byte_wdata) && !pc_q[8]
			&& pc_q[AW-1:AW-2] == $past(page_sel_q))
		else $error("Low byte write ignored page bits.");
endmodule // program_flow

// ==== rtl/return_stack.sv ====
module return_stack #(
	parameter int AW = 11
) (
	input wire logic clk_sys,
	input wire logic rst,
	stack_if.stack sif
);
	logic [AW-1:0] level1_q;
	logic [AW-1:0] level2_q;

	// Two levels only; level two keeps its value when popped.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			level1_q <= '0;
			level2_q <= '0;
		end else if (sif.push) begin
			level2_q <= level1_q;
			level1_q <= sif.push_addr;
		end else if (sif.pop) begin
			level1_q <= level2_q;
		end
	end

	assign sif.top_of_stack = level1_q;

	a_push_shift: assert property (@(posedge clk_sys) disable iff (rst)
		sif.push |=> level2_q == $past(level1_q) && level1_q == $past(sif.push_addr))
		else $error("Push did not shift the stack.");
	a_pop_keep: assert property (@(posedge clk_sys) disable iff (rst)
		sif.pop && !sif.push |=> level2_q == $past(level2_q) && level1_q == $past(level2_q))
		else $error("Pop did not keep level two.");
endmodule // return_stack

// ==== rtl/stack_if.sv ====
interface stack_if #(
	parameter int AW = 11
);
	logic push;
	logic pop;
	logic [AW-1:0] push_addr;
	logic [AW-1:0] top_of_stack;
	modport core (output push, output pop, output push_addr, input top_of_stack);
	modport stack (input push, input pop, input push_addr, output top_of_stack);
endinterface
